// ---- rtl/tsc_device.sv ----
// Touch converter device end: control byte capture, power modes, result shift-out
//
// How it works
// - Mode 00: off after conversion or CS rise
// - Mode 00: next control byte powers up
// - Mode 00: first conversion after power-up valid
// - Mode 10: off after conversion or CS rise
// - Mode 10: next byte restores power, valid
// - Mode 01: reference off, converter on
// - CS rise powers down, aborts conversion
// - CS rise leaves reference state alone
// - Host clears upper bit to drop reference
// - Host may stretch acquisition via clock
// - Host may repeat differential conversions
// - Host uses polarity 0 phase 0
// - Output changes falling, sampled just before next fall
// - Twelve bits as two bytes, zero padded
// - Output tri-stated while CS high
// - Host starts with CS low, start bit
// - Busy falling marks result bits ready
// - Host captures 16 bits after busy
// - Host raises CS after reading
// - Mode 11: both stay powered after conversion
// - First high on input is start bit
// - Busy from eighth rise to ninth fall, then twelve result bits
// - Reset into power-down, select bits zero
`timescale 1ns/1ns
`default_nettype none
module tsc_device #(
  parameter logic [tsc_pkg::RESULT_BITS-1:0] SAMPLE_BASE = 12'ha55
) (
  input wire logic REF_CLK,
  input wire logic RST,
  tsc_link_if.device LINK,
  input wire logic [tsc_pkg::RESULT_BITS-1:0] SAMPLE,
  output logic [1:0] POWER_SELECT,
  output logic CONVERTER_ON,
  output logic REFERENCE_ON,
  output logic RESULT_VALID,
  output logic [tsc_pkg::RESULT_BITS-1:0] LAST_RESULT
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_BUSY = 2'b11,
    ST_CONV = 2'b10
  } dev_state_t;

  logic [2:0] sync_q;
  logic cs_n;
  logic sclk;
  logic sin;
  logic sclk_prev;
  logic cs_prev;
  logic rise;
  logic fall;
  logic cs_rise;
  dev_state_t state;
  logic [tsc_pkg::CNT_W-1:0] bit_cnt;
  logic [tsc_pkg::CTRL_BITS-1:0] ctrl_shift;
  logic [tsc_pkg::RESULT_BITS-1:0] result_shift;
  logic [tsc_pkg::RESULT_BITS-1:0] sample_hold;
  logic valid_first;
  logic conv_done;
  logic cmd_done;
  logic [1:0] next_sel;

  tsc_sync #(.WIDTH(3)) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d({LINK.chip_select_n, LINK.host_serial_clock, LINK.serial_in}),
    .q(sync_q)
  );

  assign cs_n = sync_q[2];
  assign sclk = sync_q[1];
  assign sin = sync_q[0];
  assign rise = sclk & ~sclk_prev;
  assign fall = ~sclk & sclk_prev;
  assign cs_rise = cs_n & ~cs_prev;
  assign cmd_done = (state == ST_CMD) && rise && (bit_cnt == 5'(tsc_pkg::CTRL_BITS - 1));
  assign conv_done = (state == ST_CONV) && fall && (bit_cnt == 5'(tsc_pkg::READ_BITS - 1));
  assign next_sel = {ctrl_shift[tsc_pkg::PWR_HI_POS - 1], sin};

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end
    else
    begin
      sclk_prev <= sclk;
      cs_prev <= cs_n;
    end
  end

  // Framing state machine
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      ctrl_shift <= '0;
    end
    else if (cs_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (rise && sin)
          begin
            state <= ST_CMD;
            bit_cnt <= 5'h1;
            ctrl_shift <= 8'h01;
          end
        end
        ST_CMD:
        begin
          if (rise)
          begin
            ctrl_shift <= {ctrl_shift[tsc_pkg::CTRL_BITS-2:0], sin};
            if (cmd_done)
            begin
              state <= ST_BUSY;
              bit_cnt <= '0;
            end
            else
            begin
              bit_cnt <= bit_cnt + 5'h1;
            end
          end
        end
        ST_BUSY:
        begin
          if (fall && bit_cnt == 5'h1)
          begin
            state <= ST_CONV;
            bit_cnt <= '0;
          end
          else if (fall)
          begin
            bit_cnt <= bit_cnt + 5'h1;
          end
        end
        ST_CONV:
        begin
          if (fall)
          begin
            if (conv_done)
            begin
              state <= ST_IDLE;
              bit_cnt <= '0;
            end
            else
            begin
              bit_cnt <= bit_cnt + 5'h1;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Power-select latch; kept over CS rise
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      POWER_SELECT <= tsc_pkg::PWR_AUTO_OFF;
    end
    else if (cmd_done)
    begin
      POWER_SELECT <= next_sel;
    end
  end

  // Converter power
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      CONVERTER_ON <= 1'b0;
    end
    else if (cs_rise)
    begin
      CONVERTER_ON <= 1'b0;
    end
    else if (cmd_done)
    begin
      CONVERTER_ON <= 1'b1;
    end
    else if (conv_done)
    begin
      CONVERTER_ON <= POWER_SELECT[tsc_pkg::PWR_LO_POS];
    end
  end

  // Reference follows upper select bit only
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      REFERENCE_ON <= 1'b0;
    end
    else if (cmd_done)
    begin
      REFERENCE_ON <= next_sel[tsc_pkg::PWR_HI_POS];
    end
  end

  // Result shifter: output on falling edges
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      result_shift <= tsc_pkg::RESULT_RESET;
      sample_hold <= tsc_pkg::RESULT_RESET;
      LINK.serial_out <= 1'b0;
      LINK.busy <= 1'b0;
      RESULT_VALID <= 1'b0;
      LAST_RESULT <= tsc_pkg::RESULT_RESET;
      valid_first <= 1'b0;
    end
    else
    begin
      if (cmd_done)
      begin
        sample_hold <= SAMPLE ^ SAMPLE_BASE;
        LINK.busy <= 1'b1;
        valid_first <= 1'b1;
      end
      else if (state == ST_BUSY && fall && bit_cnt == 5'h1)
      begin
        LINK.busy <= 1'b0;
        result_shift <= sample_hold;
      end
      if (state == ST_CONV && fall)
      begin
        if (bit_cnt < 5'(tsc_pkg::RESULT_BITS))
        begin
          LINK.serial_out <= result_shift[tsc_pkg::RESULT_BITS-1];
          result_shift <= {result_shift[tsc_pkg::RESULT_BITS-2:0], 1'b0};
        end
        else
        begin
          LINK.serial_out <= 1'b0;
        end
      end
      RESULT_VALID <= conv_done & valid_first;
      if (conv_done)
      begin
        LAST_RESULT <= sample_hold;
      end
      if (cs_n)
      begin
        LINK.busy <= 1'b0;
        LINK.serial_out <= 1'b0;
      end
    end
  end

  // Drivers off while deselected
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      LINK.serial_out_oe <= 1'b0;
      LINK.busy_oe <= 1'b0;
    end
    else
    begin
      LINK.serial_out_oe <= ~cs_n;
      LINK.busy_oe <= ~cs_n;
    end
  end
endmodule : tsc_device
`default_nettype wire

// ---- rtl/tsc_pkg.sv ----
// Shared constants for the touch converter serial link
package tsc_pkg;
  localparam int CTRL_BITS = 8;
  localparam int RESULT_BITS = 12;
  localparam int READ_BITS = 16;
  localparam int PAD_BITS = 4;
  localparam int CNT_W = 5;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] HALF_PERIOD_DEF = 8'h04;
  localparam logic [1:0] PWR_AUTO_OFF = 2'h0;
  localparam logic [1:0] PWR_REF_OFF = 2'h1;
  localparam logic [1:0] PWR_ADC_OFF = 2'h2;
  localparam logic [1:0] PWR_FULL = 2'h3;
  localparam int PWR_HI_POS = 1;
  localparam int PWR_LO_POS = 0;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 12'h000;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_RESULT = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam int CTRL_GO_POS = 0;
  localparam int CTRL_CS_OFF_POS = 1;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_DONE_POS = 1;
endpackage : tsc_pkg

// ---- rtl/tsc_link_if.sv ----
// Serial link between the touch converter and its host
`timescale 1ns/1ns
`default_nettype none
interface tsc_link_if;
  logic chip_select_n;
  logic host_serial_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic busy;
  logic busy_oe;
  modport device (input chip_select_n, input host_serial_clock, input serial_in,
    output serial_out, output serial_out_oe, output busy, output busy_oe);
  modport host (output chip_select_n, output host_serial_clock, output serial_in,
    input serial_out, input serial_out_oe, input busy, input busy_oe);
endinterface : tsc_link_if
`default_nettype wire

// ---- rtl/tsc_sync.sv ----
// Two-stage synchroniser for link inputs
`timescale 1ns/1ns
`default_nettype none
module tsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1 <= '0;
      q <= '0;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule : tsc_sync
`default_nettype wire

// ---- rtl/tsc_host.sv ----
// Host end: register port, clock divider, control byte out, result capture
`timescale 1ns/1ns
`default_nettype none
module tsc_host #(
  parameter logic [tsc_pkg::DIV_W-1:0] HALF_PERIOD = tsc_pkg::HALF_PERIOD_DEF
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  tsc_link_if.host LINK
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_WAIT = 2'b11,
    H_READ = 2'b10
  } host_state_t;

  logic [2:0] sync_q;
  logic so;
  logic busy_s;
  logic busy_prev;
  host_state_t state;
  logic [tsc_pkg::DIV_W-1:0] div;
  logic tick;
  logic [tsc_pkg::CTRL_BITS-1:0] cmd;
  logic [tsc_pkg::CTRL_BITS-1:0] tx;
  logic [tsc_pkg::READ_BITS-1:0] rx;
  logic [tsc_pkg::CNT_W-1:0] cnt;
  logic done;
  logic [tsc_pkg::RESULT_BITS-1:0] result;

  tsc_sync #(.WIDTH(3)) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d({LINK.serial_out, LINK.busy, LINK.serial_out_oe}),
    .q(sync_q)
  );
  assign so = sync_q[2];
  assign busy_s = sync_q[1];
  assign tick = (div == HALF_PERIOD - 8'h01);

  always_ff @(posedge REF_CLK)
  begin
    if (RST || state == H_IDLE)
    begin
      div <= '0;
    end
    else
    begin
      div <= tick ? '0 : div + 8'h01;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      busy_prev <= 1'b0;
    end
    else
    begin
      busy_prev <= busy_s;
    end
  end

  // Serial sequencer, clock idles low
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state <= H_IDLE;
      LINK.chip_select_n <= 1'b1;
      LINK.host_serial_clock <= 1'b0;
      LINK.serial_in <= 1'b0;
      tx <= '0;
      rx <= '0;
      cnt <= '0;
      done <= 1'b0;
      result <= tsc_pkg::RESULT_RESET;
    end
    else
    begin
      case (state)
        H_IDLE:
        begin
          if (WR && ADDR == tsc_pkg::REG_CTRL && WDATA[tsc_pkg::CTRL_GO_POS])
          begin
            state <= H_SEND;
            LINK.chip_select_n <= 1'b0;
            tx <= {1'b1, cmd[tsc_pkg::CTRL_BITS-2:0]};
            cnt <= '0;
            done <= 1'b0;
          end
        end
        H_SEND:
        begin
          if (tick)
          begin
            if (!LINK.host_serial_clock)
            begin
              LINK.serial_in <= tx[tsc_pkg::CTRL_BITS-1];
              tx <= {tx[tsc_pkg::CTRL_BITS-2:0], 1'b0};
              LINK.host_serial_clock <= 1'b1;
            end
            else
            begin
              LINK.host_serial_clock <= 1'b0;
              cnt <= cnt + 5'h1;
              if (cnt == 5'(tsc_pkg::CTRL_BITS - 1))
              begin
                state <= H_WAIT;
                LINK.serial_in <= 1'b0;
                cnt <= '0;
              end
            end
          end
        end
        H_WAIT, H_READ:
        begin
          if (tick)
          begin
            LINK.host_serial_clock <= ~LINK.host_serial_clock;
            if (LINK.host_serial_clock && state == H_READ)
            begin
              // Sample before the fall to cover sync delay; first sample is stale
              rx <= {rx[tsc_pkg::READ_BITS-2:0], so};
              cnt <= cnt + 5'h1;
              if (cnt == 5'(tsc_pkg::READ_BITS))
              begin
                state <= H_IDLE;
                LINK.chip_select_n <= 1'b1;
                done <= 1'b1;
                result <= rx[tsc_pkg::READ_BITS-2 -: tsc_pkg::RESULT_BITS];
              end
            end
          end
          if (state == H_WAIT && busy_prev && !busy_s)
          begin
            state <= H_READ;
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
      if (WR && ADDR == tsc_pkg::REG_CTRL && WDATA[tsc_pkg::CTRL_CS_OFF_POS])
      begin
        state <= H_IDLE;
        LINK.chip_select_n <= 1'b1;
        LINK.host_serial_clock <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      cmd <= '0;
    end
    else if (WR && ADDR == tsc_pkg::REG_CMD)
    begin
      cmd <= WDATA[tsc_pkg::CTRL_BITS-1:0];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      RDATA <= '0;
    end
    else if (RD)
    begin
      case (ADDR)
        tsc_pkg::REG_CMD: RDATA <= {24'h0000_00, cmd};
        tsc_pkg::REG_STATUS: RDATA <= {30'h0000_0000, done, state != H_IDLE};
        tsc_pkg::REG_RESULT: RDATA <= {20'h0000_0, result};
        default: RDATA <= '0;
      endcase
    end
    else
    begin
      RDATA <= '0;
    end
  end
endmodule : tsc_host
`default_nettype wire

// ---- bench/tsc_link_asserts.sv ----
// Protocol checker for the converter serial link
`timescale 1ns/1ns
`default_nettype none
module tsc_link_asserts (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic chip_select_n,
  input wire logic host_serial_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic busy,
  input wire logic busy_oe
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic sclk_q;
  logic [4:0] bits;
  logic [4:0] rises;
  wire logic sclk_rise;
  assign sclk_rise = host_serial_clock & ~sclk_q;
  always_ff @(posedge REF_CLK)
  begin
    sclk_q <= host_serial_clock;
  end
  // Rising clock edges since the frame opened
  always_ff @(posedge REF_CLK)
  begin
    if (RST || chip_select_n)
      bits <= 5'h00;
    else if (sclk_rise)
      bits <= bits + 5'h01;
  end
  // Rising clock edges since busy fell, saturating
  always_ff @(posedge REF_CLK)
  begin
    if (RST || busy)
      rises <= 5'h00;
    else if (sclk_rise && rises != 5'h1f)
      rises <= rises + 5'h01;
  end
  property p_oe_off;
    chip_select_n [*4] |-> !serial_out_oe && !busy_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs driven while deselected");
  property p_abort;
    $rose(chip_select_n) |-> ##[1:5] !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("busy kept after deselect");
  property p_idle_low;
    $fell(chip_select_n) |-> !host_serial_clock;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("frame opened with clock high");
  property p_change_low;
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !host_serial_clock;
  endproperty
  a_change_low: assert property (p_change_low) else $error("data changed while clock high");
  property p_busy_len;
    $rose(busy) |-> (busy || chip_select_n) [*6] ##[1:10] !busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy pulse width wrong");
  property p_busy_start;
    $rose(busy) |-> !chip_select_n && bits == 5'h08;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not after eight bits");
  property p_pad;
    sclk_rise && !chip_select_n && rises >= 5'h0d && rises <= 5'h10 |-> !serial_out;
  endproperty
  a_pad: assert property (p_pad) else $error("trailing bit not zero");
  property p_ready;
    $fell(busy) && !chip_select_n |-> serial_out_oe;
  endproperty
  a_ready: assert property (p_ready) else $error("result not driven at busy fall");
  c_conv: cover property ($fell(busy));
  c_abort: cover property ($rose(chip_select_n) && busy);
  c_pad: cover property (sclk_rise && rises == 5'h0f);
endmodule : tsc_link_asserts
`default_nettype wire

// ---- bench/tb_touch_adc_power_serial_ctrl.sv ----
// Self-checking bench for host and converter ends
`timescale 1ns/1ns
`default_nettype none
module tb_touch_adc_power_serial_ctrl;
  localparam logic [11:0] BASE = 12'hc3a;
  logic REF_CLK;
  logic RST;
  logic [3:0] ADDR;
  logic [31:0] WDATA;
  logic WR;
  logic RD;
  logic [31:0] RDATA;
  logic [11:0] SAMPLE;
  logic [1:0] POWER_SELECT;
  logic CONVERTER_ON;
  logic REFERENCE_ON;
  logic RESULT_VALID;
  logic [11:0] LAST_RESULT;
  logic [31:0] rd_val;
  int errors = 0;
  int n_checks = 0;
  tsc_link_if u_tsc_link_if ();
  tsc_host #(.HALF_PERIOD(tsc_pkg::HALF_PERIOD_DEF)) u_tsc_host (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINK(u_tsc_link_if));
  tsc_device #(.SAMPLE_BASE(BASE)) u_tsc_device (.REF_CLK(REF_CLK), .RST(RST), .LINK(u_tsc_link_if),
    .SAMPLE(SAMPLE), .POWER_SELECT(POWER_SELECT), .CONVERTER_ON(CONVERTER_ON), .REFERENCE_ON(REFERENCE_ON),
    .RESULT_VALID(RESULT_VALID), .LAST_RESULT(LAST_RESULT));
  tsc_link_asserts u_tsc_link_asserts (.REF_CLK(REF_CLK), .RST(RST),
    .chip_select_n(u_tsc_link_if.chip_select_n), .host_serial_clock(u_tsc_link_if.host_serial_clock),
    .serial_in(u_tsc_link_if.serial_in), .serial_out(u_tsc_link_if.serial_out),
    .serial_out_oe(u_tsc_link_if.serial_out_oe), .busy(u_tsc_link_if.busy), .busy_oe(u_tsc_link_if.busy_oe));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic give_up;
    check(32'h0000_0000, 32'h0000_0001);
    report_and_stop();
  endtask : give_up

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge REF_CLK);
    WR <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge REF_CLK);
    RD <= 1'h0;
    #1;
    rd_val = RDATA;
  endtask : reg_rd

  // One full conversion in the given mode, then deselect
  task automatic convert(input logic [7:0] cmd, input logic [11:0] smp);
    logic [11:0] exp;
    int i;
    exp = smp ^ BASE;
    SAMPLE <= smp;
    reg_wr(tsc_pkg::REG_CMD, 32'(cmd));
    reg_wr(tsc_pkg::REG_CTRL, 32'h0000_0001);
    for (i = 0; i < 400 && u_tsc_link_if.busy !== 1'h1; i++)
      @(posedge REF_CLK) #1;
    if (i == 400)
      give_up();
    repeat (2) @(posedge REF_CLK) #1;
    check(32'(CONVERTER_ON), 32'h0000_0001);
    for (i = 0; i < 400 && RESULT_VALID !== 1'h1; i++)
      @(posedge REF_CLK) #1;
    if (i == 400)
      give_up();
    check(32'(LAST_RESULT), 32'(exp));
    repeat (2) @(posedge REF_CLK) #1;
    check(32'({POWER_SELECT, CONVERTER_ON, REFERENCE_ON}), 32'({cmd[1:0], cmd[0], cmd[1]}));
    for (i = 0; i < 100; i++)
    begin
      reg_rd(tsc_pkg::REG_STATUS);
      if (rd_val[tsc_pkg::STAT_BUSY_POS] === 1'h0)
        break;
    end
    if (i == 100)
      give_up();
    reg_rd(tsc_pkg::REG_RESULT);
    check(rd_val, 32'(exp));
    reg_wr(tsc_pkg::REG_CTRL, 32'h0000_0002);
    repeat (8) @(posedge REF_CLK) #1;
    check(32'({CONVERTER_ON, REFERENCE_ON, u_tsc_link_if.serial_out_oe}), 32'({1'h0, cmd[1], 1'h0}));
  endtask : convert

  // Deselect in mid-conversion at full power
  task automatic abort_mid;
    logic seen;
    int i;
    seen = 1'h0;
    reg_wr(tsc_pkg::REG_CMD, 32'h0000_0083);
    reg_wr(tsc_pkg::REG_CTRL, 32'h0000_0001);
    for (i = 0; i < 400 && u_tsc_link_if.busy !== 1'h1; i++)
      @(posedge REF_CLK) #1;
    if (i == 400)
      give_up();
    reg_wr(tsc_pkg::REG_CTRL, 32'h0000_0002);
    repeat (200)
    begin
      @(posedge REF_CLK) #1;
      if (RESULT_VALID !== 1'h0)
        seen = 1'h1;
    end
    check(32'({seen, CONVERTER_ON, REFERENCE_ON, u_tsc_link_if.busy}), 32'h0000_0002);
  endtask : abort_mid

  initial
  begin
    REF_CLK = 1'h0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  initial
  begin
    RST = 1'h1;
    ADDR = 4'h0;
    WDATA = 32'h0000_0000;
    WR = 1'h0;
    RD = 1'h0;
    SAMPLE = 12'h000;
    repeat (4) @(posedge REF_CLK);
    RST <= 1'h0;
    @(posedge REF_CLK) #1;
    check(32'({POWER_SELECT, CONVERTER_ON, REFERENCE_ON, u_tsc_link_if.chip_select_n}), 32'h0000_0001);
    reg_rd(4'hf);
    check(rd_val, 32'h0000_0000);
    convert(8'h02, 12'h000);
    convert(8'h80, 12'hfff);
    convert(8'h81, 12'h5a5);
    convert(8'h83, 12'h3c3);
    convert(8'h80, 12'h801);
    abort_mid();
    report_and_stop();
  end
endmodule : tb_touch_adc_power_serial_ctrl
`default_nettype wire
